// ==== sim/port_master.sv ====
// Bus master model driving both ports of the dual-port RAM
`timescale 1ns/1ns

module port_master (
  input  wire logic                         clk,
  output      logic [dpram_port_pkg::ADDR_W-1:0] addr  [2],
  output      logic                         rw    [2],
  output      logic                         ld_n  [2],
  output      logic                         adv_n [2],
  output      logic                         clr_n [2],
  output      logic                         sl    [2],
  output      logic                         sh    [2],
  output      logic                         ub_n  [2],
  output      logic                         lb_n  [2],
  output      logic                         gate_n[2],
  output      logic [17:0]                  dq    [2]
);
  import dpram_port_pkg::*;
  // ==========================================================
  // Idle: selected, reading, address loading
  initial begin
    for (int p = 0; p < 2; p++) begin
      addr[p] = 15'h0000;
      rw[p] = 1'b1;
      ld_n[p] = 1'b0;
      adv_n[p] = 1'b1;
      clr_n[p] = 1'b1;
      sl[p] = 1'b0;
      sh[p] = 1'b1;
      ub_n[p] = 1'b0;
      lb_n[p] = 1'b0;
      gate_n[p] = 1'b0;
      dq[p] = 18'h00000;
    end
  end
  // ==========================================================
  // Tasks, called just after a falling edge
  task automatic op(input int p, input logic r, input logic [14:0] a,
                    input logic [17:0] d, input logic [1:0] ln);
    addr[p] = a;
    rw[p] = r;
    ld_n[p] = 1'b0;
    adv_n[p] = 1'b1;
    clr_n[p] = 1'b1;
    // Released data bus toggles so stale data cannot pass
    dq[p] = r ? ~dq[p] : d;
    // One control set per word: ub_n enables the upper lane, lb_n the lower
    ub_n[p] = ln[1];
    lb_n[p] = ln[0];
  endtask
  task automatic ctl(input int p, input logic l, input logic v,
                     input logic c);
    ld_n[p] = l;
    adv_n[p] = v;
    clr_n[p] = c;
    addr[p] = ~addr[p];
  endtask
  // Caller holds reselect three cycles before expecting data
  task automatic sel(input int p, input logic lo, input logic hi);
    sl[p] = lo;
    sh[p] = hi;
  endtask
  task automatic gate(input int p, input logic g);
    gate_n[p] = g;
  endtask
  task automatic step();
    @(negedge clk);
  endtask
endmodule

// ==== sim/sram_dual_port_tb.sv ====
// Self-checking bench for the pipelined dual-port RAM ports
`timescale 1ns/1ns

module sram_dual_port_tb;
  import dpram_port_pkg::*;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] addr  [PORTS];
  logic              rw    [PORTS];
  logic              ld_n  [PORTS];
  logic              adv_n [PORTS];
  logic              clr_n [PORTS];
  logic              sl    [PORTS];
  logic              sh    [PORTS];
  logic              ub_n  [PORTS];
  logic              lb_n  [PORTS];
  logic              gate_n[PORTS];
  logic [17:0]       dq_in [PORTS];
  logic [17:0]       dq_out[PORTS];
  logic [1:0]        dq_oe [PORTS];
  logic              lp    [PORTS];
  int                err_count = 0;
  int                cmp_count = 0;
  int                cycles = 0;

  port_master m (.clk(clk), .addr(addr), .rw(rw), .ld_n(ld_n),
    .adv_n(adv_n), .clr_n(clr_n), .sl(sl), .sh(sh), .ub_n(ub_n),
    .lb_n(lb_n), .gate_n(gate_n), .dq(dq_in));
  sram_dual_port dut (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr),
    .READ_WRITE(rw), .ADDRESS_LOAD_STROBE_N(ld_n),
    .COUNT_ADVANCE_N(adv_n), .COUNT_CLEAR_N(clr_n),
    .SELECT_ACTIVE_LOW(sl), .SELECT_ACTIVE_HIGH(sh),
    .UPPER_LANE_ENABLE_N(ub_n), .LOWER_LANE_ENABLE_N(lb_n),
    .OUTPUT_GATE_N(gate_n), .DQ_IN(dq_in), .DQ_OUT(dq_out),
    .DQ_OE(dq_oe), .LOW_POWER(lp));
  // ==========================================================
  // Checks and run control
  task automatic chk_dq(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ctl(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Read then wait until its data is due
  task automatic rd(input int p, input logic [14:0] a, input logic [1:0] ln);
    m.op(p, 1'b1, a, 18'h00000, ln);
    repeat (3) m.step();
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_wr_rd();
    m.op(0, 1'b0, 15'h0100, 18'h1A5A5, 2'h0);
    m.step();
    m.op(0, 1'b0, 15'h0101, 18'h0C3C3, 2'h0);
    m.step();
    m.op(0, 1'b0, 15'h0000, 18'h00011, 2'h0);
    m.op(1, 1'b1, 15'h0100, 18'h00000, 2'h0);
    m.step();
    m.op(0, 1'b1, 15'h0000, 18'h00000, 2'h0);
    m.op(1, 1'b1, 15'h0101, 18'h00000, 2'h0);
    repeat (2) m.step();
    chk_dq(dq_out[1], 18'h1A5A5);
    chk_ctl(dq_oe[1], 2'h3);
    m.step();
    chk_dq(dq_out[1], 18'h0C3C3);
    chk_dq(dq_out[0], 18'h00011);
    chk_ctl(dq_oe[1], 2'h3);
    chk_ctl(dq_oe[0], 2'h3);
    chk_ctl({1'b0, lp[0]}, 2'h0);
    $display("t_wr_rd done");
  endtask
  task automatic t_lanes();
    m.op(1, 1'b0, 15'h0101, 18'h3FFFF, 2'h1);
    m.step();
    rd(1, 15'h0101, 2'h2);
    chk_ctl(dq_oe[1], 2'h1);
    chk_dq({9'h000, dq_out[1][8:0]}, 18'h001C3);
    m.op(1, 1'b1, 15'h0101, 18'h00000, 2'h3);
    repeat (2) m.step();
    chk_ctl(dq_oe[1], 2'h0);
    m.step();
    rd(1, 15'h0101, 2'h0);
    chk_dq(dq_out[1], 18'h3FFC3);
    $display("t_lanes done");
  endtask
  task automatic t_count();
    m.op(1, 1'b1, 15'h0100, 18'h00000, 2'h0);
    m.step();
    m.ctl(1, 1'b1, 1'b0, 1'b1);
    m.step();
    m.ctl(1, 1'b1, 1'b1, 1'b1);
    m.step();
    chk_dq(dq_out[1], 18'h1A5A5);
    m.step();
    chk_dq(dq_out[1], 18'h3FFC3);
    m.ctl(1, 1'b1, 1'b1, 1'b0);
    m.step();
    chk_dq(dq_out[1], 18'h3FFC3);
    m.ctl(1, 1'b1, 1'b1, 1'b1);
    repeat (2) m.step();
    chk_dq(dq_out[1], 18'h00011);
    $display("t_count done");
  endtask
  task automatic t_sel();
    for (int i = 0; i < 2; i++) begin
      rd(1, 15'h0100, 2'h0);
      m.sel(1, i == 0, i == 0);
      m.step();
      chk_ctl({1'b0, lp[1]}, 2'h1);
      m.sel(1, 1'b0, 1'b1);
      m.step();
      chk_ctl(dq_oe[1], 2'h0);
      chk_ctl({1'b0, lp[1]}, 2'h0);
      m.step();
      chk_ctl(dq_oe[1], 2'h0);
      m.step();
      chk_ctl(dq_oe[1], 2'h3);
    end
    m.gate(1, 1'b1);
    #1 chk_ctl(dq_oe[1], 2'h0);
    m.step();
    chk_ctl(dq_oe[1], 2'h0);
    m.gate(1, 1'b0);
    #1 chk_ctl(dq_oe[1], 2'h3);
    m.step();
    $display("t_sel done");
  endtask
  task automatic t_clash();
    m.op(0, 1'b0, 15'h0200, 18'h00F0F, 2'h0);
    m.step();
    m.op(0, 1'b0, 15'h0200, 18'h3C0F0, 2'h0);
    m.op(1, 1'b1, 15'h0200, 18'h00000, 2'h0);
    m.step();
    m.op(0, 1'b1, 15'h0000, 18'h00000, 2'h0);
    m.op(1, 1'b1, 15'h0101, 18'h00000, 2'h0);
    repeat (2) m.step();
    chk_dq(dq_out[1], 18'h00F0F);
    m.op(0, 1'b0, 15'h0201, 18'h12345, 2'h0);
    m.step();
    chk_dq(dq_out[1], 18'h3C0F0);
    m.op(0, 1'b1, 15'h0000, 18'h00000, 2'h0);
    rd(1, 15'h0201, 2'h0);
    chk_dq(dq_out[1], 18'h12345);
    m.op(0, 1'b0, 15'h0200, 18'h3C0F0, 2'h0);
    m.step();
    m.op(0, 1'b1, 15'h0000, 18'h00000, 2'h0);
    rd(1, 15'h0200, 2'h0);
    chk_dq(dq_out[1], 18'h3C0F0);
    $display("t_clash done");
  endtask
  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Ceiling well above the few dozen cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      $display("Watchdog expired at %0t", $time);
      close_out();
    end
  end
  initial begin
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk_dq(dq_out[0], 18'h00000);
    chk_ctl(dq_oe[0], 2'h0);
    chk_ctl({1'b0, lp[1]}, 2'h1);
    t_wr_rd();
    t_lanes();
    t_count();
    t_sel();
    t_clash();
    close_out();
  end
endmodule

// ==== verilog/sram_array.sv ====
// Shared two-port storage array with byte-lane writes and registered reads
`timescale 1ns/1ns

module sram_array #(
  parameter int ADDR_W = 15,
  parameter int LANE_W = 9
) (
  input  wire logic                  clk,
  input  wire logic [ADDR_W-1:0]     addr    [2],
  input  wire logic [1:0]            wr_lane [2],
  input  wire logic [2*LANE_W-1:0]   wdata   [2],
  output      logic [2*LANE_W-1:0]   rdata_q [2]
);

  // ==========================================================
  // Storage
  // Read-first on both ports; a write lands at the edge that
  // closes its access cycle, with no dependence on its timing.
  logic [2*LANE_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      rdata_q[p] <= mem[addr[p]];
      for (int l = 0; l < 2; l++) begin
        // Port 1 wins a same-address, same-lane clash
        if (wr_lane[p][l]) begin
          mem[addr[p]][l*LANE_W +: LANE_W] <= wdata[p][l*LANE_W +: LANE_W];
        end
      end
    end
  end

endmodule

// ==== verilog/sram_dual_port.sv ====
// Constants and top level of the pipelined dual-port static RAM

package dpram_port_pkg;
  // ==========================================================
  // Geometry
  localparam int          PORTS     = 2;
  localparam int          ADDR_W    = 15;
  localparam int          LANE_W    = 9;
  localparam int          LANES     = 2;
  localparam int          DEPTH     = 32768;
  localparam int          UPPER     = 1;
  localparam int          LOWER     = 0;
  // ==========================================================
  // Lane masks and clock period
  localparam logic [1:0]  LANES_OFF = 2'h0;
  localparam logic [1:0]  LANES_ALL = 2'h3;
  localparam int          CLK_PERIOD_NS = 4;
endpackage

`timescale 1ns/1ns

module sram_dual_port #(
  parameter int ADDR_W = dpram_port_pkg::ADDR_W,
  parameter int LANE_W = dpram_port_pkg::LANE_W
) (
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST_N,
  input  wire logic [ADDR_W-1:0]     ADDR                  [dpram_port_pkg::PORTS],
  input  wire logic                  READ_WRITE            [dpram_port_pkg::PORTS],
  input  wire logic                  ADDRESS_LOAD_STROBE_N [dpram_port_pkg::PORTS],
  input  wire logic                  COUNT_ADVANCE_N       [dpram_port_pkg::PORTS],
  input  wire logic                  COUNT_CLEAR_N         [dpram_port_pkg::PORTS],
  input  wire logic                  SELECT_ACTIVE_LOW     [dpram_port_pkg::PORTS],
  input  wire logic                  SELECT_ACTIVE_HIGH    [dpram_port_pkg::PORTS],
  input  wire logic                  UPPER_LANE_ENABLE_N   [dpram_port_pkg::PORTS],
  input  wire logic                  LOWER_LANE_ENABLE_N   [dpram_port_pkg::PORTS],
  input  wire logic                  OUTPUT_GATE_N         [dpram_port_pkg::PORTS],
  input  wire logic [2*LANE_W-1:0]   DQ_IN                 [dpram_port_pkg::PORTS],
  output      logic [2*LANE_W-1:0]   DQ_OUT                [dpram_port_pkg::PORTS],
  output      logic [1:0]            DQ_OE                 [dpram_port_pkg::PORTS],
  output      logic                  LOW_POWER             [dpram_port_pkg::PORTS]
);
  import dpram_port_pkg::*;

  localparam int WORD_W = 2 * LANE_W;

  // ==========================================================
  // Elaboration checks
  // The lane steering is hard-wired for two lanes of equal width.
  if (ADDR_W < 1 || ADDR_W > 20) begin : g_bad_addr
    $error("ADDR_W out of range");
  end
  if (LANE_W < 1) begin : g_bad_lane
    $error("LANE_W must be positive");
  end

  // ==========================================================
  // Per-port state
  logic [ADDR_W-1:0] addr_q     [PORTS];
  logic [ADDR_W-1:0] addr_d     [PORTS];
  logic              sel_d      [PORTS];
  logic [1:0]        lane_d     [PORTS];
  logic              sel_q      [PORTS];
  logic              rd_q       [PORTS];
  logic [1:0]        rd_lane_q  [PORTS];
  logic [1:0]        wr_lane_q  [PORTS];
  logic [WORD_W-1:0] din_q      [PORTS];
  logic              rd2_q      [PORTS];
  logic [1:0]        rd_lane2_q [PORTS];
  logic              coll_d     [PORTS];
  logic              coll2_q    [PORTS];
  logic              fix_q      [PORTS];
  logic [WORD_W-1:0] cdat2_q    [PORTS];
  logic [1:0]        clane2_q   [PORTS];
  logic [WORD_W-1:0] cdat3_q    [PORTS];
  logic [1:0]        clane3_q   [PORTS];
  logic [WORD_W-1:0] dout_q     [PORTS];
  logic [1:0]        oe_q       [PORTS];
  logic [WORD_W-1:0] rdata      [PORTS];

  // ==========================================================
  // Shared array
  sram_array #(
    .ADDR_W (ADDR_W),
    .LANE_W (LANE_W)
  ) u_array (
    .clk     (CORE_CLK),
    .addr    (addr_q),
    .wr_lane (wr_lane_q),
    .wdata   (din_q),
    .rdata_q (rdata)
  );

  for (genvar gp = 0; gp < PORTS; gp++) begin : g_port
    localparam int OP = 1 - gp;

    // ========================================================
    // Input decode
    // Both selects must be asserted; either one alone banks out.
    assign sel_d[gp] = ~SELECT_ACTIVE_LOW[gp] & SELECT_ACTIVE_HIGH[gp];
    assign lane_d[gp] = {~UPPER_LANE_ENABLE_N[gp],
                         ~LOWER_LANE_ENABLE_N[gp]};

    // ========================================================
    // Burst address counter
    // Clear outranks load so the clear cycle itself uses address 0.
    always_comb begin
      if (!COUNT_CLEAR_N[gp]) begin
        addr_d[gp] = '0;
      end else if (!ADDRESS_LOAD_STROBE_N[gp]) begin
        addr_d[gp] = ADDR[gp];
      end else if (!COUNT_ADVANCE_N[gp]) begin
        addr_d[gp] = ADDR_W'(addr_q[gp] + 1'b1);
      end else begin
        addr_d[gp] = addr_q[gp];
      end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        addr_q[gp] <= '0;
      end else begin
        addr_q[gp] <= addr_d[gp];
      end
    end

    // ========================================================
    // Input registers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        sel_q[gp]     <= 1'b0;
        rd_q[gp]      <= 1'b0;
        rd_lane_q[gp] <= LANES_OFF;
        wr_lane_q[gp] <= LANES_OFF;
        din_q[gp]     <= '0;
      end else begin
        sel_q[gp]     <= sel_d[gp];
        rd_q[gp]      <= sel_d[gp] & READ_WRITE[gp];
        rd_lane_q[gp] <= lane_d[gp];
        wr_lane_q[gp] <= (sel_d[gp] & ~READ_WRITE[gp]) ? lane_d[gp]
                                                       : LANES_OFF;
        din_q[gp]     <= DQ_IN[gp];
      end
    end

    // ========================================================
    // Same-edge write from the other port
    // The array is read-first, so this read sees stale data; the
    // written lanes are kept and patched in one cycle late.
    assign coll_d[gp] = rd_q[gp] && (wr_lane_q[OP] != LANES_OFF)
                        && (addr_q[OP] == addr_q[gp]);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        rd2_q[gp]      <= 1'b0;
        rd_lane2_q[gp] <= LANES_OFF;
        coll2_q[gp]    <= 1'b0;
        cdat2_q[gp]    <= '0;
        clane2_q[gp]   <= LANES_OFF;
        fix_q[gp]      <= 1'b0;
        cdat3_q[gp]    <= '0;
        clane3_q[gp]   <= LANES_OFF;
      end else begin
        rd2_q[gp]      <= rd_q[gp];
        rd_lane2_q[gp] <= rd_lane_q[gp];
        coll2_q[gp]    <= coll_d[gp];
        cdat2_q[gp]    <= din_q[OP];
        clane2_q[gp]   <= wr_lane_q[OP];
        fix_q[gp]      <= coll2_q[gp];
        cdat3_q[gp]    <= cdat2_q[gp];
        clane3_q[gp]   <= clane2_q[gp];
      end
    end

    // ========================================================
    // Output register
    // A patch cycle overrides the next read's data; the master is
    // expected to leave that slot idle after a same-edge clash.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        dout_q[gp] <= '0;
      end else if (fix_q[gp]) begin
        for (int l = 0; l < LANES; l++) begin
          if (clane3_q[gp][l]) begin
            dout_q[gp][l*LANE_W +: LANE_W] <=
              cdat3_q[gp][l*LANE_W +: LANE_W];
          end
        end
      end else if (rd2_q[gp]) begin
        dout_q[gp] <= rdata[gp];
      end
    end

    // Drive state is decided by controls captured one edge earlier,
    // so deselect is fast but reselect waits for the read pipeline.
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
        oe_q[gp] <= LANES_OFF;
      end else if (!sel_q[gp] || rd_lane_q[gp] == LANES_OFF) begin
        oe_q[gp] <= LANES_OFF;
      end else if (rd2_q[gp]) begin
        oe_q[gp] <= rd_lane2_q[gp];
      end else begin
        oe_q[gp] <= LANES_OFF;
      end
    end

    assign DQ_OUT[gp]    = dout_q[gp];
    assign DQ_OE[gp]     = OUTPUT_GATE_N[gp] ? LANES_OFF : oe_q[gp];
    assign LOW_POWER[gp] = ~sel_q[gp];

    // ========================================================
    // Checks
    property p_clear;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !COUNT_CLEAR_N[gp] |=> addr_q[gp] == '0;
    endproperty
    a_clear: assert property (p_clear)
      else $error("Counter not cleared");

    property p_load;
      @(posedge CORE_CLK) disable iff (!RST_N)
      COUNT_CLEAR_N[gp] && !ADDRESS_LOAD_STROBE_N[gp]
        |=> addr_q[gp] == $past(ADDR[gp]);
    endproperty
    a_load: assert property (p_load)
      else $error("External address not loaded");

    property p_incr;
      @(posedge CORE_CLK) disable iff (!RST_N)
      COUNT_CLEAR_N[gp] && ADDRESS_LOAD_STROBE_N[gp] && !COUNT_ADVANCE_N[gp]
        |=> addr_q[gp] == ADDR_W'($past(addr_q[gp]) + 1'b1);
    endproperty
    a_incr: assert property (p_incr)
      else $error("Counter did not advance by one");

    property p_hold;
      @(posedge CORE_CLK) disable iff (!RST_N)
      COUNT_CLEAR_N[gp] && ADDRESS_LOAD_STROBE_N[gp] && COUNT_ADVANCE_N[gp]
        |=> $stable(addr_q[gp]);
    endproperty
    a_hold: assert property (p_hold)
      else $error("Counter moved while stalled");

    property p_deselect;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !sel_d[gp] |=> ##1 oe_q[gp] == LANES_OFF;
    endproperty
    a_deselect: assert property (p_deselect)
      else $error("Outputs driven after deselect");

    property p_read_latency;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (sel_d[gp] && READ_WRITE[gp] && lane_d[gp] == LANES_ALL)
        ##1 (sel_d[gp] && lane_d[gp] != LANES_OFF)
        |=> ##1 oe_q[gp] == LANES_ALL;
    endproperty
    a_read_latency: assert property (p_read_latency)
      else $error("Read data not driven on time");

    property p_lane_off;
      @(posedge CORE_CLK) disable iff (!RST_N)
      sel_d[gp] && READ_WRITE[gp] && lane_d[gp] == 2'h1
        |=> ##2 !oe_q[gp][UPPER];
    endproperty
    a_lane_off: assert property (p_lane_off)
      else $error("Disabled lane driven");

    property p_write_quiet;
      @(posedge CORE_CLK) disable iff (!RST_N)
      sel_d[gp] && !READ_WRITE[gp] |=> ##2 oe_q[gp] == LANES_OFF;
    endproperty
    a_write_quiet: assert property (p_write_quiet)
      else $error("Outputs driven for a write");

    property p_gate;
      @(posedge CORE_CLK) disable iff (!RST_N)
      OUTPUT_GATE_N[gp] |-> DQ_OE[gp] == LANES_OFF;
    endproperty
    a_gate: assert property (p_gate)
      else $error("Outputs driven with gate off");

    property p_low_power;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !sel_d[gp] |=> LOW_POWER[gp];
    endproperty
    a_low_power: assert property (p_low_power)
      else $error("Low power not entered on deselect");
  end

endmodule
